// ---- rtl/cdr_regs_pkg.sv ----
// Constants for the receiver control and status register bank.
// Assumes a byte-wide management port that decodes 8-bit register addresses.
package cdr_regs_pkg;

    // ---------------------------------------------------------------
    // Register addresses
    // ---------------------------------------------------------------
    localparam logic [7:0] addr_freq_readback_low = 8'h00;
    localparam logic [7:0] addr_freq_readback_mid = 8'h01;
    localparam logic [7:0] addr_freq_readback_high = 8'h02;
    localparam logic [7:0] addr_coarse_rate_upper = 8'h03;
    localparam logic [7:0] addr_status_flags = 8'h04;
    localparam logic [7:0] addr_lock_config_readback = 8'h05;
    localparam logic [7:0] addr_reset_config_readback = 8'h06;
    localparam logic [7:0] addr_lock_config = 8'h08;
    localparam logic [7:0] addr_reset_config = 8'h09;
    localparam logic [7:0] addr_subharmonic_config = 8'h0d;
    localparam logic [7:0] addr_signal_detect_config = 8'h11;
    localparam logic [7:0] addr_driver_prbs_config = 8'h22;
    localparam logic [7:0] addr_bus_align_config = 8'h27;
    localparam logic [7:0] addr_rate_select_config = 8'h34;
    localparam logic [7:0] addr_upper_code_limit = 8'h35;
    localparam logic [7:0] addr_lower_code_limit = 8'h36;
    localparam logic [7:0] addr_code_limit_lsbs = 8'h39;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int status_los_bit = 5;
    localparam int status_sticky_bit = 4;
    localparam int status_lock_loss_bit = 3;
    localparam int status_meas_done_bit = 2;
    localparam int status_coarse_lsb_bit = 0;
    localparam int lock_ref_bit = 0;
    localparam int measure_bit = 1;
    localparam int cfg_sticky_out_bit = 7;
    localparam int clear_sticky_bit = 6;
    localparam int system_reset_bit = 5;
    localparam int clear_meas_bit = 3;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] write_reg_reset = 8'h00;
    localparam logic [7:0] unmapped_read = 8'h00;

    typedef enum logic [1:0] {
        meas_idle = 2'b00,
        meas_busy = 2'b01,
        meas_done = 2'b10
    } meas_state_type;

endpackage

// ---- rtl/cdr_control_status_regs.sv ----
// Control and status register bank of the clock and data recovery receiver.
// Assumes a management port decoder that gives one-cycle read and write strobes
// with address and data on sys_clk_i; analog status arrives asynchronously.
//
// What this block does
// - Writable registers clear to zero at reset
// - Status D5 reports loss of signal
// - Status D4 sticks at one after lock loss
// - Cleared sticky bit rearms for next loss
// - Status D2 zero measuring, one when complete
// - Lock config D1 starts rate measurement
// - Reset config D7 selects sticky lock-loss output
// - Lock config D0 selects lock to reference
`timescale 1ns/1ps
`default_nettype none

module cdr_control_status_regs
    import cdr_regs_pkg::*;
#(
    parameter int data_width = 8
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic wr_strobe_i,
    input wire logic rd_strobe_i,
    input wire logic [7:0] addr_i,
    input wire logic [data_width-1:0] wr_data_i,
    output logic [data_width-1:0] rd_data_o,
    input wire logic los_i,
    input wire logic lock_loss_i,
    input wire logic meas_done_i,
    input wire logic [23:0] freq_count_i,
    input wire logic [8:0] coarse_rate_i,
    output logic lock_loss_o,
    output logic lock_to_ref_o,
    output logic meas_start_o,
    output logic system_reset_o,
    output logic [data_width-1:0] lock_config_o,
    output logic [data_width-1:0] subharmonic_config_o,
    output logic [data_width-1:0] signal_detect_config_o,
    output logic [data_width-1:0] driver_prbs_config_o,
    output logic [data_width-1:0] bus_align_config_o,
    output logic [data_width-1:0] rate_select_config_o,
    output logic [data_width-1:0] upper_code_limit_o,
    output logic [data_width-1:0] lower_code_limit_o,
    output logic [data_width-1:0] code_limit_lsbs_o
);

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic los;
    logic lock_loss;
    logic meas_flag;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end else begin
            sync_a <= {meas_done_i, lock_loss_i, los_i};
            sync_b <= sync_a;
        end
    end

    assign los = sync_b[0];
    assign lock_loss = sync_b[1];
    assign meas_flag = sync_b[2];

    // ---------------------------------------------------------------
    // Writable registers
    // ---------------------------------------------------------------
    logic [data_width-1:0] lock_config, next_lock_config;
    logic [data_width-1:0] reset_config, next_reset_config;
    logic [data_width-1:0] subharmonic_config, next_subharmonic_config;
    logic [data_width-1:0] signal_detect_config, next_signal_detect_config;
    logic [data_width-1:0] driver_prbs_config, next_driver_prbs_config;
    logic [data_width-1:0] bus_align_config, next_bus_align_config;
    logic [data_width-1:0] rate_select_config, next_rate_select_config;
    logic [data_width-1:0] upper_code_limit, next_upper_code_limit;
    logic [data_width-1:0] lower_code_limit, next_lower_code_limit;
    logic [data_width-1:0] code_limit_lsbs, next_code_limit_lsbs;

    always_comb begin
        next_lock_config = lock_config;
        next_reset_config = reset_config;
        next_subharmonic_config = subharmonic_config;
        next_signal_detect_config = signal_detect_config;
        next_driver_prbs_config = driver_prbs_config;
        next_bus_align_config = bus_align_config;
        next_rate_select_config = rate_select_config;
        next_upper_code_limit = upper_code_limit;
        next_lower_code_limit = lower_code_limit;
        next_code_limit_lsbs = code_limit_lsbs;
        if (wr_strobe_i) begin
            case (addr_i)
                addr_lock_config: next_lock_config = wr_data_i;
                addr_reset_config: next_reset_config = wr_data_i;
                addr_subharmonic_config: next_subharmonic_config = wr_data_i;
                addr_signal_detect_config: next_signal_detect_config = wr_data_i;
                addr_driver_prbs_config: next_driver_prbs_config = wr_data_i;
                addr_bus_align_config: next_bus_align_config = wr_data_i;
                addr_rate_select_config: next_rate_select_config = wr_data_i;
                addr_upper_code_limit: next_upper_code_limit = wr_data_i;
                addr_lower_code_limit: next_lower_code_limit = wr_data_i;
                addr_code_limit_lsbs: next_code_limit_lsbs = wr_data_i;
                default: next_lock_config = lock_config;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            lock_config <= write_reg_reset;
            reset_config <= write_reg_reset;
            subharmonic_config <= write_reg_reset;
            signal_detect_config <= write_reg_reset;
            driver_prbs_config <= write_reg_reset;
            bus_align_config <= write_reg_reset;
            rate_select_config <= write_reg_reset;
            upper_code_limit <= write_reg_reset;
            lower_code_limit <= write_reg_reset;
            code_limit_lsbs <= write_reg_reset;
        end else begin
            lock_config <= next_lock_config;
            reset_config <= next_reset_config;
            subharmonic_config <= next_subharmonic_config;
            signal_detect_config <= next_signal_detect_config;
            driver_prbs_config <= next_driver_prbs_config;
            bus_align_config <= next_bus_align_config;
            rate_select_config <= next_rate_select_config;
            upper_code_limit <= next_upper_code_limit;
            lower_code_limit <= next_lower_code_limit;
            code_limit_lsbs <= next_code_limit_lsbs;
        end
    end

    // ---------------------------------------------------------------
    // Sticky lock loss and measurement tracking
    // ---------------------------------------------------------------
    logic sticky, next_sticky;
    logic meas_start, next_meas_start;
    logic prev_measure, next_prev_measure;
    meas_state_type meas_state, next_meas_state;

    always_comb begin
        next_sticky = sticky;
        // Clear holds while the reset bit is one; a loss in that cycle still sets
        if (reset_config[clear_sticky_bit]) begin
            next_sticky = 1'b0;
        end
        if (lock_loss) begin
            next_sticky = 1'b1;
        end
        next_prev_measure = lock_config[measure_bit];
        next_meas_start = lock_config[measure_bit] & ~prev_measure;
        next_meas_state = meas_state;
        case (meas_state)
            meas_idle: begin
                if (meas_start) begin
                    next_meas_state = meas_busy;
                end
            end
            meas_busy: begin
                if (meas_flag) begin
                    next_meas_state = meas_done;
                end
            end
            meas_done: begin
                if (meas_start) begin
                    next_meas_state = meas_busy;
                end else if (reset_config[clear_meas_bit]) begin
                    next_meas_state = meas_idle;
                end
            end
            default: next_meas_state = meas_idle;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sticky <= 1'b0;
            meas_start <= 1'b0;
            prev_measure <= 1'b0;
            meas_state <= meas_idle;
        end else begin
            sticky <= next_sticky;
            meas_start <= next_meas_start;
            prev_measure <= next_prev_measure;
            meas_state <= next_meas_state;
        end
    end

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    logic [data_width-1:0] status_word;
    logic [data_width-1:0] rd_data, next_rd_data;
    logic next_lock_loss_o;
    logic next_lock_to_ref_o;
    logic next_meas_start_o;
    logic next_system_reset_o;

    always_comb begin
        status_word = '0;
        status_word[status_los_bit] = los;
        status_word[status_sticky_bit] = sticky;
        status_word[status_lock_loss_bit] = lock_loss;
        status_word[status_meas_done_bit] = (meas_state == meas_done);
        status_word[status_coarse_lsb_bit] = coarse_rate_i[0];
        next_rd_data = rd_data;
        if (rd_strobe_i) begin
            case (addr_i)
                addr_freq_readback_low: next_rd_data = freq_count_i[7:0];
                addr_freq_readback_mid: next_rd_data = freq_count_i[15:8];
                addr_freq_readback_high: next_rd_data = {1'b0, freq_count_i[22:16]};
                addr_coarse_rate_upper: next_rd_data = coarse_rate_i[8:1];
                addr_status_flags: next_rd_data = status_word;
                addr_lock_config_readback: next_rd_data = lock_config;
                addr_reset_config_readback: next_rd_data = reset_config;
                default: next_rd_data = unmapped_read;
            endcase
        end
        next_lock_loss_o = reset_config[cfg_sticky_out_bit] ? sticky : lock_loss;
        next_lock_to_ref_o = lock_config[lock_ref_bit];
        next_meas_start_o = meas_start;
        next_system_reset_o = reset_config[system_reset_bit];
    end

    // ---------------------------------------------------------------
    // Registered outputs
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rd_data <= unmapped_read;
            lock_loss_o <= 1'b0;
            lock_to_ref_o <= 1'b0;
            meas_start_o <= 1'b0;
            system_reset_o <= 1'b0;
        end else begin
            rd_data <= next_rd_data;
            lock_loss_o <= next_lock_loss_o;
            lock_to_ref_o <= next_lock_to_ref_o;
            meas_start_o <= next_meas_start_o;
            system_reset_o <= next_system_reset_o;
        end
    end

    assign rd_data_o = rd_data;
    assign lock_config_o = lock_config;
    assign subharmonic_config_o = subharmonic_config;
    assign signal_detect_config_o = signal_detect_config;
    assign driver_prbs_config_o = driver_prbs_config;
    assign bus_align_config_o = bus_align_config;
    assign rate_select_config_o = rate_select_config;
    assign upper_code_limit_o = upper_code_limit;
    assign lower_code_limit_o = lower_code_limit;
    assign code_limit_lsbs_o = code_limit_lsbs;

endmodule

`default_nettype wire

// ---- dv/cdr_regs_props.sv ----
// Concurrent checks on the register bank ports.
// Assumes cdr_regs_pkg is compiled first; bound below.
`timescale 1ns/1ps
`default_nettype none

module cdr_regs_props
    import cdr_regs_pkg::*;
#(
    parameter int data_width = 8
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic wr_strobe_i,
    input wire logic rd_strobe_i,
    input wire logic [7:0] addr_i,
    input wire logic [data_width-1:0] wr_data_i,
    input wire logic [data_width-1:0] rd_data_o,
    input wire logic los_i,
    input wire logic lock_loss_i,
    input wire logic lock_loss_o,
    input wire logic lock_to_ref_o,
    input wire logic meas_start_o,
    input wire logic [data_width-1:0] lock_config_o,
    input wire logic [data_width-1:0] subharmonic_config_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    reset_clears_a: assert property (disable iff (1'b0) sys_rst_i |=> lock_config_o == 8'h00 && !meas_start_o)
        else $error("register not cleared by reset");
    los_read_a: assert property ($stable(los_i) [*4] ##0 (rd_strobe_i && addr_i == addr_status_flags)
        |=> rd_data_o[status_los_bit] == $past(los_i)) else $error("status loss bit wrong");
    loss_pin_a: assert property (lock_loss_i [*5] |-> lock_loss_o)
        else $error("lock loss output missing");
    ref_copy_a: assert property (lock_to_ref_o == $past(lock_config_o[lock_ref_bit]))
        else $error("lock source output wrong");
    start_pulse_a: assert property ($rose(lock_config_o[measure_bit]) |=> ##1 meas_start_o ##1 !meas_start_o)
        else $error("measure start pulse wrong");
    wr_take_a: assert property (wr_strobe_i && addr_i == addr_lock_config |=> lock_config_o == $past(wr_data_i))
        else $error("lock config write lost");
    wr_guard_a: assert property (!(wr_strobe_i && addr_i == addr_subharmonic_config)
        |=> $stable(subharmonic_config_o)) else $error("stray register change");
    rd_copy_a: assert property (rd_strobe_i && addr_i == addr_lock_config_readback
        |=> rd_data_o == $past(lock_config_o)) else $error("readback copy wrong");
    rd_wo_a: assert property (rd_strobe_i && addr_i == addr_lock_config |=> rd_data_o == unmapped_read)
        else $error("write-only address readable");
endmodule

bind cdr_control_status_regs cdr_regs_props #(.data_width(data_width)) props (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .wr_strobe_i(wr_strobe_i), .rd_strobe_i(rd_strobe_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .los_i(los_i), .lock_loss_i(lock_loss_i),
    .lock_loss_o(lock_loss_o), .lock_to_ref_o(lock_to_ref_o), .meas_start_o(meas_start_o),
    .lock_config_o(lock_config_o), .subharmonic_config_o(subharmonic_config_o));
`default_nettype wire

// ---- dv/rate_meter_model.sv ----
// Behavioural data-rate meter feeding the register bank.
// Assumes the measure request is a level; slow_i picks a long measurement.
`timescale 1ns/1ps
`default_nettype none

module rate_meter_model #(
    parameter logic [23:0] freq_value = 24'h000000,
    parameter logic [8:0] coarse_value = 9'h000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic meas_req_i,
    input wire logic slow_i,
    output logic meas_done_o,
    output logic [23:0] freq_count_o,
    output logic [8:0] coarse_rate_o
);
    logic req_q;
    logic [7:0] cnt;

    assign freq_count_o = meas_done_o ? freq_value : 24'h000000;
    assign coarse_rate_o = meas_done_o ? coarse_value : 9'h000;

    // Done holds while the request stays up, drops when it is withdrawn
    always_ff @(posedge clk_i) begin
        req_q <= meas_req_i;
        if (rst_i || !meas_req_i) begin
            cnt <= 8'h00;
            meas_done_o <= 1'b0;
        end else if (!req_q) begin
            cnt <= slow_i ? 8'h28 : 8'h04;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
            meas_done_o <= (cnt == 8'h01);
        end
    end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the register bank.
// Assumes the package, design, checker and meter model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import cdr_regs_pkg::*;
    localparam logic [23:0] freq_value = 24'hbc5a96;
    localparam logic [8:0] coarse_value = 9'h14b;
    localparam logic [7:0] wo_addr [8] = '{addr_subharmonic_config, addr_signal_detect_config,
        addr_driver_prbs_config, addr_bus_align_config, addr_rate_select_config, addr_upper_code_limit,
        addr_lower_code_limit, addr_code_limit_lsbs};
    logic sys_clk = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0, los = 1'b0, lock_loss = 1'b0, slow = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v, lock_cfg;
    logic [7:0] cfg [8];
    logic mdone, lock_loss_out, ref_o, mstart, sysrst;
    logic [23:0] freq;
    logic [8:0] coarse;
    int bad_count = 0;
    int n_checks = 0;

    always #2.5 sys_clk = ~sys_clk;

    cdr_control_status_regs dut (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .wr_strobe_i(wr), .rd_strobe_i(rd),
        .addr_i(addr), .wr_data_i(wdata), .rd_data_o(rdata), .los_i(los), .lock_loss_i(lock_loss),
        .meas_done_i(mdone), .freq_count_i(freq), .coarse_rate_i(coarse), .lock_loss_o(lock_loss_out),
        .lock_to_ref_o(ref_o),
        .meas_start_o(mstart), .system_reset_o(sysrst), .lock_config_o(lock_cfg), .subharmonic_config_o(cfg[0]),
        .signal_detect_config_o(cfg[1]), .driver_prbs_config_o(cfg[2]), .bus_align_config_o(cfg[3]),
        .rate_select_config_o(cfg[4]), .upper_code_limit_o(cfg[5]), .lower_code_limit_o(cfg[6]),
        .code_limit_lsbs_o(cfg[7]));
    rate_meter_model #(.freq_value(freq_value), .coarse_value(coarse_value)) meter (.clk_i(sys_clk),
        .rst_i(sys_rst), .meas_req_i(lock_cfg[measure_bit]), .slow_i(slow), .meas_done_o(mdone),
        .freq_count_o(freq), .coarse_rate_o(coarse));

    task automatic summarize();
        if (bad_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge sys_clk);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(negedge sys_clk);
        addr = a;
        rd = 1'b1;
        @(negedge sys_clk);
        rd = 1'b0;
        v = rdata;
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        rd_reg(a);
        chk(name, exp, v);
    endtask
    task automatic lock_loss_burst();
        lock_loss = 1'b1;
        idle(5);
        lock_loss = 1'b0;
        idle(5);
        rd_reg(addr_status_flags);
    endtask

    initial begin
        repeat (2000) @(posedge sys_clk);
        bad_count++;
        summarize();
    end

    initial begin
        idle(5);
        sys_rst = 1'b0;
        chk("lock_config", 8'h00, lock_cfg);
        rd_chk("reset readback", addr_reset_config_readback, 8'h00);
        for (int i = 0; i < 8; i++) begin
            chk("config out", 8'h00, cfg[i]);
            wr_reg(wo_addr[i], 8'(8'h11 * (i + 1)));
        end
        wr_reg(8'h07, 8'hff);
        chk("lock_config", 8'h00, lock_cfg);
        for (int i = 0; i < 8; i++) begin
            chk("config out", 8'(8'h11 * (i + 1)), cfg[i]);
            rd_chk("write-only read", wo_addr[i], 8'h00);
        end
        rd_chk("hole read", 8'h07, 8'h00);
        wr_reg(addr_lock_config, 8'h01);
        idle(2);
        chk("lock_to_ref", 8'h01, {7'h00, ref_o});
        wr_reg(addr_lock_config_readback, 8'hff);
        rd_chk("lock readback", addr_lock_config_readback, 8'h01);
        rd_chk("write-only read", addr_lock_config, 8'h00);
        wr_reg(addr_lock_config, 8'h02);
        idle(2);
        rd_reg(addr_status_flags);
        chk("meas busy", 8'h00, {7'h00, v[status_meas_done_bit]});
        idle(60);
        rd_reg(addr_status_flags);
        chk("meas done", 8'h01, {7'h00, v[status_meas_done_bit]});
        chk("coarse lsb", {7'h00, coarse_value[0]}, {7'h00, v[0]});
        rd_chk("freq low", addr_freq_readback_low, freq_value[7:0]);
        rd_chk("freq mid", addr_freq_readback_mid, freq_value[15:8]);
        rd_chk("freq high", addr_freq_readback_high, {1'b0, freq_value[22:16]});
        rd_chk("coarse", addr_coarse_rate_upper, coarse_value[8:1]);
        wr_reg(addr_reset_config, 8'h08);
        wr_reg(addr_reset_config, 8'h00);
        rd_reg(addr_status_flags);
        chk("meas cleared", 8'h00, {7'h00, v[status_meas_done_bit]});
        wr_reg(addr_lock_config, 8'h00);
        slow = 1'b0;
        idle(5);
        wr_reg(addr_lock_config, 8'h02);
        idle(2);
        chk("meas start", 8'h01, {7'h00, mstart});
        idle(1);
        chk("meas start", 8'h00, {7'h00, mstart});
        idle(9);
        rd_reg(addr_status_flags);
        chk("prompt meas", 8'h01, {7'h00, v[status_meas_done_bit]});
        for (int k = 1; k >= 0; k--) begin
            los = k[0];
            idle(5);
            rd_reg(addr_status_flags);
            chk("loss status", {7'h00, k[0]}, {7'h00, v[status_los_bit]});
        end
        lock_loss_burst();
        chk("sticky set", 8'h01, {7'h00, v[status_sticky_bit]});
        chk("live lock", 8'h00, {7'h00, v[status_lock_loss_bit]});
        chk("lock_loss_o", 8'h00, {7'h00, lock_loss_out});
        wr_reg(addr_reset_config, 8'h80);
        idle(2);
        chk("sticky out", 8'h01, {7'h00, lock_loss_out});
        wr_reg(addr_reset_config, 8'hc0);
        wr_reg(addr_reset_config, 8'h80);
        rd_reg(addr_status_flags);
        chk("sticky clear", 8'h00, {7'h00, v[status_sticky_bit]});
        chk("sticky out", 8'h00, {7'h00, lock_loss_out});
        lock_loss_burst();
        chk("sticky rearm", 8'h01, {7'h00, v[status_sticky_bit]});
        wr_reg(addr_reset_config, 8'h20);
        idle(2);
        chk("system_reset_o", 8'h01, {7'h00, sysrst});
        summarize();
    end
endmodule
`default_nettype wire
